//--- hw/pad_mux_pkg.sv
// Package for the pad override and indicator pin output mux.
// Assumes a 16-bit management register port with one-cycle read latency.
package pad_mux_pkg;

	localparam int REG_AW = 11;
	localparam int REG_DW = 16;

	// Register offsets
	localparam logic [REG_AW-1:0] PAD_OVERRIDE_CONFIG_ADDR = 11'h461;
	localparam logic [REG_AW-1:0] INDICATOR_PIN_OUTPUT_SELECT_ADDR = 11'h462;

	// Reset values
	localparam logic [REG_DW-1:0] PAD_OVERRIDE_CONFIG_RST = 16'h0005;
	localparam logic [REG_DW-1:0] INDICATOR_PIN_OUTPUT_SELECT_RST = 16'h0000;

	// Writable bits; reserved bits 10-6 of the pad register read zero
	localparam logic [REG_DW-1:0] PAD_OVERRIDE_CONFIG_WMASK = 16'hf83f;
	localparam logic [REG_DW-1:0] INDICATOR_PIN_OUTPUT_SELECT_WMASK = 16'hffff;

	// Pad register fields
	localparam int DIR_VALUE_BIT = 15;
	localparam int DIR_FORCE_BIT = 14;
	localparam int PULL_VALUE_LSB = 12;
	localparam int PULL_FORCE_BIT = 11;
	localparam int STRENGTH_LSB = 0;
	localparam int NUM_STRENGTH = 3;

	// Output select register fields, pin 0 at lane 0, pin 2 at lane 1
	localparam int PIN_FIELD_STRIDE = 8;
	localparam int SEL_LSB = 0;
	localparam int INV_BIT = 3;
	localparam int SRC_LSB = 4;
	localparam int DIV_BIT = 7;

	// Default indicator function code for pin 0
	localparam logic [3:0] PIN0_INDICATOR_DEFAULT = 4'h8;

	typedef enum logic [2:0] {
		OSEL_INDICATOR = 3'b000,
		OSEL_CLOCK = 3'b001,
		OSEL_INTERRUPT = 3'b010,
		OSEL_LOW = 3'b011,
		OSEL_RSVD4 = 3'b100,
		OSEL_RSVD5 = 3'b101,
		OSEL_ZERO = 3'b110,
		OSEL_ONE = 3'b111
	} out_sel_e;

	typedef enum logic [2:0] {
		CSRC_CRYSTAL = 3'b000,
		CSRC_LD30 = 3'b001,
		CSRC_ADC30 = 3'b010,
		CSRC_FREE60 = 3'b011,
		CSRC_C7P5 = 3'b100,
		CSRC_PLL25 = 3'b101,
		CSRC_C2P5 = 3'b110,
		CSRC_NONE = 3'b111
	} clk_src_e;

	// Clock sources seen by the mux
	typedef struct packed {
		logic crystal_input_clock;
		logic free_ld30;
		logic rec_ld30;
		logic rec_adc30;
		logic free60;
		logic free_c7p5;
		logic rec_c7p5;
		logic pll25;
		logic free_c2p5;
		logic rec_c2p5;
	} clk_srcs_s;

	// Pad overrides applied to the pad ring
	typedef struct packed {
		logic dir_force;
		logic dir_input;
		logic pull_force;
		logic [1:0] pull_value;
		logic [NUM_STRENGTH-1:0][1:0] strength;
		logic [NUM_STRENGTH-1:0] fast_slew;
	} pad_ctrl_s;

endpackage

//--- hw/pad_override_and_pin_output_mux.sv
// Pad override and indicator pin output mux, two registers and two pin muxes.
// Assumes all sources and the register port are synchronous to sys_clk_i.
//
// Summary of operation
// - Direction override bit forces all pads except management and reset pads.
// - Direction value 0 makes overridden pads outputs, 1 makes them inputs.
// - Pull override bit takes pad pulls from register control.
// - Two-bit pull value field gives the applied pull setting.
// - Low bit of each MAC pad strength field selects fast slew.
// - Pin 2 select: indicator, clock, interrupt, low, reserved, zero, one.
// - Pin 0 select uses the same encoding with its own indicator.
// - Pin 2 clock source field chooses one of seven clocks.
// - Pin 0 clock source field uses the same seven codes.
// - Line-driver, 7.5 and 2.5 MHz sources follow master or slave role.
// - Code 5 delivers the 25 MHz PLL reference.
// - Pin 2 divide bit halves the selected clock.
// - Pin 2 invert bit inverts the selected clock.
// - Pin 0 divide bit halves the selected clock.
// - Pin 0 invert bit inverts the selected clock.
// - Pin 0 indicator defaults to link with stretched activity blink.
`timescale 1ns/1ps

module pad_override_and_pin_output_mux
#(
	parameter int NUM_PINS = 2
)
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [pad_mux_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [pad_mux_pkg::REG_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [pad_mux_pkg::REG_DW-1:0] reg_rdata_o,
	input wire pad_mux_pkg::clk_srcs_s clk_srcs_i,
	input wire logic link_master_i,
	input wire logic [NUM_PINS-1:0] indicator_i,
	input wire logic interrupt_i,
	output logic [3:0] pin0_indicator_func_o,
	output pad_mux_pkg::pad_ctrl_s pad_ctrl_o,
	output logic [NUM_PINS-1:0] pin_out_o
);
	import pad_mux_pkg::*;

	generate
		if (NUM_PINS != 2)
		begin : g_pins_check
			$error("NUM_PINS must be 2");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [REG_DW-1:0] pad_cfg;
	logic [REG_DW-1:0] pin_sel;
	logic [REG_DW-1:0] rdata;
	logic [REG_DW-1:0] next_pad_cfg;
	logic [REG_DW-1:0] next_pin_sel;
	logic [REG_DW-1:0] next_rdata;

	function automatic logic [REG_DW-1:0] masked_write(input logic [REG_DW-1:0] old,
		input logic [REG_DW-1:0] wdata, input logic [REG_DW-1:0] wmask);
		masked_write = (old & ~wmask) | (wdata & wmask);
	endfunction

	always_comb
	begin
		next_pad_cfg = pad_cfg;
		next_pin_sel = pin_sel;
		next_rdata = '0;
		if (reg_wr_i && reg_addr_i == PAD_OVERRIDE_CONFIG_ADDR)
			next_pad_cfg = masked_write(pad_cfg, reg_wdata_i, PAD_OVERRIDE_CONFIG_WMASK);
		else if (reg_wr_i && reg_addr_i == INDICATOR_PIN_OUTPUT_SELECT_ADDR)
			next_pin_sel = masked_write(pin_sel, reg_wdata_i, INDICATOR_PIN_OUTPUT_SELECT_WMASK);
		if (reg_rd_i && reg_addr_i == PAD_OVERRIDE_CONFIG_ADDR)
			next_rdata = pad_cfg & PAD_OVERRIDE_CONFIG_WMASK;
		else if (reg_rd_i && reg_addr_i == INDICATOR_PIN_OUTPUT_SELECT_ADDR)
			next_rdata = pin_sel;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pad_cfg <= PAD_OVERRIDE_CONFIG_RST;
			pin_sel <= INDICATOR_PIN_OUTPUT_SELECT_RST;
			rdata <= '0;
		end
		else
		begin
			pad_cfg <= next_pad_cfg;
			pin_sel <= next_pin_sel;
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_o = rdata;

	// ---------------------------------------------------------------
	// Pad overrides
	// ---------------------------------------------------------------
	pad_ctrl_s next_pad_ctrl;

	always_comb
	begin
		next_pad_ctrl.dir_force = pad_cfg[DIR_FORCE_BIT];
		next_pad_ctrl.dir_input = pad_cfg[DIR_FORCE_BIT] & pad_cfg[DIR_VALUE_BIT];
		next_pad_ctrl.pull_force = pad_cfg[PULL_FORCE_BIT];
		next_pad_ctrl.pull_value = pad_cfg[PULL_FORCE_BIT] ?
			pad_cfg[PULL_VALUE_LSB +: 2] : 2'h0;
		for (int i = 0; i < NUM_STRENGTH; i++)
		begin
			next_pad_ctrl.strength[i] = pad_cfg[STRENGTH_LSB + 2*i +: 2];
			next_pad_ctrl.fast_slew[i] = pad_cfg[STRENGTH_LSB + 2*i];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pad_ctrl_o <= '0;
		else
			pad_ctrl_o <= next_pad_ctrl;
	end

	assign pin0_indicator_func_o = PIN0_INDICATOR_DEFAULT;

	// ---------------------------------------------------------------
	// Clock source selection
	// ---------------------------------------------------------------
	function automatic logic pick_clock(input logic [2:0] src, input clk_srcs_s c,
		input logic master);
		case (clk_src_e'(src))
			CSRC_CRYSTAL: pick_clock = c.crystal_input_clock;
			CSRC_LD30: pick_clock = master ? c.free_ld30 : c.rec_ld30;
			CSRC_ADC30: pick_clock = c.rec_adc30;
			CSRC_FREE60: pick_clock = c.free60;
			CSRC_C7P5: pick_clock = master ? c.free_c7p5 : c.rec_c7p5;
			CSRC_PLL25: pick_clock = c.pll25;
			CSRC_C2P5: pick_clock = master ? c.free_c2p5 : c.rec_c2p5;
			default: pick_clock = 1'b0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Per-pin output mux
	// ---------------------------------------------------------------
	logic [NUM_PINS-1:0] src_clk;
	logic [NUM_PINS-1:0] src_prev;
	logic [NUM_PINS-1:0] half_clk;
	logic [NUM_PINS-1:0] next_src_prev;
	logic [NUM_PINS-1:0] next_half_clk;
	logic [NUM_PINS-1:0] next_pin_out;

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_pin
			logic [2:0] sel;
			logic [2:0] src;
			logic div_en;
			logic inv_en;
			logic clk_pre;

			assign sel = pin_sel[g*PIN_FIELD_STRIDE + SEL_LSB +: 3];
			assign src = pin_sel[g*PIN_FIELD_STRIDE + SRC_LSB +: 3];
			assign div_en = pin_sel[g*PIN_FIELD_STRIDE + DIV_BIT];
			assign inv_en = pin_sel[g*PIN_FIELD_STRIDE + INV_BIT];

			always_comb
			begin
				src_clk[g] = pick_clock(src, clk_srcs_i, link_master_i);
				next_src_prev[g] = src_clk[g];
				// Toggle on each rising edge of the sampled source
				next_half_clk[g] = half_clk[g] ^ (src_clk[g] & ~src_prev[g]);
				// Divide first, then invert
				clk_pre = div_en ? half_clk[g] : src_clk[g];
				case (out_sel_e'(sel))
					OSEL_INDICATOR: next_pin_out[g] = indicator_i[g];
					OSEL_CLOCK: next_pin_out[g] = clk_pre ^ inv_en;
					OSEL_INTERRUPT: next_pin_out[g] = interrupt_i;
					OSEL_ONE: next_pin_out[g] = 1'b1;
					default: next_pin_out[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			src_prev <= '0;
			half_clk <= '0;
			pin_out_o <= '0;
		end
		else
		begin
			src_prev <= next_src_prev;
			half_clk <= next_half_clk;
			pin_out_o <= next_pin_out;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_dir_force_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == PAD_OVERRIDE_CONFIG_ADDR && reg_wdata_i[DIR_FORCE_BIT])
		|-> ##2 pad_ctrl_o.dir_force)
		else $error("direction override not applied");

	a_dir_value_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pad_ctrl_o.dir_input |-> pad_ctrl_o.dir_force)
		else $error("direction value active without override");

	a_pull_force_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pad_ctrl_o.pull_force == $past(pad_cfg[PULL_FORCE_BIT]))
		else $error("pull override not applied");

	a_pull_value_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(pad_cfg[PULL_FORCE_BIT]) |-> pad_ctrl_o.pull_value == $past(pad_cfg[13:12]))
		else $error("pull value wrong");

	a_slew_bit_map: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pad_ctrl_o.fast_slew == {pad_ctrl_o.strength[2][0], pad_ctrl_o.strength[1][0],
		pad_ctrl_o.strength[0][0]})
		else $error("slew bit mismatch");

	a_pin2_const_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pin_sel[10:8] == OSEL_ONE |=> pin_out_o[1])
		else $error("pin 2 constant one wrong");

	a_pin0_irq_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pin_sel[2:0] == OSEL_INTERRUPT |=> pin_out_o[0] == $past(interrupt_i))
		else $error("pin 0 interrupt route wrong");

	a_rsvd_code_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(pin_sel[2:1] == 2'h2) |=> !pin_out_o[0])
		else $error("reserved code not low");

	a_rsvd_read_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_rd_i && reg_addr_i == PAD_OVERRIDE_CONFIG_ADDR) |=> reg_rdata_o[10:6] == 5'h0)
		else $error("reserved bits not zero");

	a_pin0_inv_clk: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(pin_sel[2:0] == OSEL_CLOCK && pin_sel[6:4] == CSRC_CRYSTAL && !pin_sel[7]
		&& pin_sel[3]) |=> pin_out_o[0] == !$past(clk_srcs_i.crystal_input_clock))
		else $error("pin 0 inversion wrong");

	a_dir_force_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == PAD_OVERRIDE_CONFIG_ADDR && !reg_wdata_i[DIR_FORCE_BIT])
		|-> ##2 !pad_ctrl_o.dir_force)
		else $error("direction override not released");

	a_dir_value_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pad_ctrl_o.dir_input == $past(pad_cfg[DIR_FORCE_BIT] && pad_cfg[DIR_VALUE_BIT]))
		else $error("direction value not applied");

	a_pull_value_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!$past(pad_cfg[PULL_FORCE_BIT]) |-> pad_ctrl_o.pull_value == 2'h0)
		else $error("pull value leaks without override");

	a_strength_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(rst_n_i) |->
		pad_ctrl_o.strength == $past(pad_cfg[STRENGTH_LSB +: 2*NUM_STRENGTH]))
		else $error("pad strength not applied");

	// ---------------------------------------------------------------
	// Pin mux assertions
	// ---------------------------------------------------------------
	a_pin2_crystal_clk: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[1].sel == OSEL_CLOCK && g_pin[1].src == CSRC_CRYSTAL && !g_pin[1].div_en)
		|=> pin_out_o[1] == ($past(clk_srcs_i.crystal_input_clock) ^ $past(g_pin[1].inv_en)))
		else $error("pin 2 crystal clock wrong");

	a_pin0_ld30_role: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[0].sel == OSEL_CLOCK && g_pin[0].src == CSRC_LD30 && !g_pin[0].div_en)
		|=> pin_out_o[0] == (($past(link_master_i) ? $past(clk_srcs_i.free_ld30)
		: $past(clk_srcs_i.rec_ld30)) ^ $past(g_pin[0].inv_en)))
		else $error("pin 0 line-driver clock wrong");

	a_pin2_c7p5_role: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[1].sel == OSEL_CLOCK && g_pin[1].src == CSRC_C7P5 && !g_pin[1].div_en)
		|=> pin_out_o[1] == (($past(link_master_i) ? $past(clk_srcs_i.free_c7p5)
		: $past(clk_srcs_i.rec_c7p5)) ^ $past(g_pin[1].inv_en)))
		else $error("pin 2 7.5 MHz clock wrong");

	a_pin0_c2p5_role: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[0].sel == OSEL_CLOCK && g_pin[0].src == CSRC_C2P5 && !g_pin[0].div_en)
		|=> pin_out_o[0] == (($past(link_master_i) ? $past(clk_srcs_i.free_c2p5)
		: $past(clk_srcs_i.rec_c2p5)) ^ $past(g_pin[0].inv_en)))
		else $error("pin 0 2.5 MHz clock wrong");

	a_pin2_pll_ref: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[1].sel == OSEL_CLOCK && g_pin[1].src == CSRC_PLL25 && !g_pin[1].div_en)
		|=> pin_out_o[1] == ($past(clk_srcs_i.pll25) ^ $past(g_pin[1].inv_en)))
		else $error("pin 2 PLL reference wrong");

	a_pin0_adc_clk: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[0].sel == OSEL_CLOCK && g_pin[0].src == CSRC_ADC30 && !g_pin[0].div_en)
		|=> pin_out_o[0] == ($past(clk_srcs_i.rec_adc30) ^ $past(g_pin[0].inv_en)))
		else $error("pin 0 converter clock wrong");

	a_pin2_free60_clk: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[1].sel == OSEL_CLOCK && g_pin[1].src == CSRC_FREE60 && !g_pin[1].div_en)
		|=> pin_out_o[1] == ($past(clk_srcs_i.free60) ^ $past(g_pin[1].inv_en)))
		else $error("pin 2 free 60 MHz clock wrong");

	a_pin2_half_rate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[1].sel == OSEL_CLOCK && g_pin[1].div_en && $stable(pin_sel)
		&& pin_sel == $past(pin_sel, 2) && $changed(pin_out_o[1])) |=> $stable(pin_out_o[1]))
		else $error("pin 2 divided clock too fast");

	a_pin0_half_rate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[0].sel == OSEL_CLOCK && g_pin[0].div_en && $stable(pin_sel)
		&& pin_sel == $past(pin_sel, 2) && $changed(pin_out_o[0])) |=> $stable(pin_out_o[0]))
		else $error("pin 0 divided clock too fast");

	a_div_then_inv: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[1].sel == OSEL_CLOCK && g_pin[1].div_en && g_pin[1].inv_en)
		|=> pin_out_o[1] == !$past(half_clk[1]))
		else $error("pin 2 divide and invert order wrong");

	a_pin2_indicator: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		g_pin[1].sel == OSEL_INDICATOR |=> pin_out_o[1] == $past(indicator_i[1]))
		else $error("pin 2 indicator route wrong");

	a_pin0_low_codes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(g_pin[0].sel == OSEL_LOW || g_pin[0].sel == OSEL_ZERO) |=> !pin_out_o[0])
		else $error("pin 0 low code not low");

	a_select_latency: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == INDICATOR_PIN_OUTPUT_SELECT_ADDR)
		|=> pin_sel == $past(reg_wdata_i & INDICATOR_PIN_OUTPUT_SELECT_WMASK))
		else $error("select write not taken");

	a_unmapped_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i != PAD_OVERRIDE_CONFIG_ADDR
		&& reg_addr_i != INDICATOR_PIN_OUTPUT_SELECT_ADDR) |=> $stable(pad_cfg) && $stable(pin_sel))
		else $error("unmapped write changed a register");

endmodule

//--- test/pad_override_and_pin_output_mux_bench.sv
// Self-checking bench for the pad override and indicator pin output mux.
// Assumes one register clock; the bench drives every design input itself.
`timescale 1ns/1ps

module pad_override_and_pin_output_mux_bench;
	import pad_mux_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [REG_AW-1:0] reg_addr_i = '0;
	logic [REG_DW-1:0] reg_wdata_i = '0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [REG_DW-1:0] reg_rdata_o;
	clk_srcs_s clk_srcs_i = '0;
	logic link_master_i = 1'b0;
	logic [1:0] indicator_i = '0;
	logic interrupt_i = 1'b0;
	logic [3:0] pin0_indicator_func_o;
	pad_ctrl_s pad_ctrl_o;
	logic [1:0] pin_out_o;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #4 sys_clk_i = ~sys_clk_i;

	pad_override_and_pin_output_mux #(.NUM_PINS(2)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .clk_srcs_i(clk_srcs_i),
		.link_master_i(link_master_i), .indicator_i(indicator_i), .interrupt_i(interrupt_i),
		.pin0_indicator_func_o(pin0_indicator_func_o), .pad_ctrl_o(pad_ctrl_o),
		.pin_out_o(pin_out_o));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Cut a hang short well past the few hundred cycles the run needs
	always @(posedge sys_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			test_done();
		end
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write, then wait until the outputs carry the new value
	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask

	task automatic rd(input logic [10:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	function automatic logic sel_exp(input int c, input logic ind, input logic irq);
		case (c)
			0: return ind;
			2: return irq;
			7: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic int src_idx(input int c, input logic m);
		case (c)
			0: return 9;
			1: return m ? 8 : 7;
			2: return 6;
			3: return 5;
			4: return m ? 4 : 3;
			5: return 2;
			default: return m ? 1 : 0;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reset_values();
		logic [15:0] v;
		rd(PAD_OVERRIDE_CONFIG_ADDR, v);
		chk("pad reset", v, 16'h0005);
		rd(INDICATOR_PIN_OUTPUT_SELECT_ADDR, v);
		chk("select reset", v, 16'h0000);
		chk("pin0 function", {12'h000, pin0_indicator_func_o}, 16'h0008);
		wr(11'h460, 16'hffff);
		rd(11'h460, v);
		chk("unmapped read", v, 16'h0000);
	endtask

	task automatic pad_case(input logic [15:0] w);
		logic [15:0] v;
		wr(PAD_OVERRIDE_CONFIG_ADDR, w);
		rd(PAD_OVERRIDE_CONFIG_ADDR, v);
		chk("pad readback", v, w & 16'hf83f);
		chk("dir force", pad_ctrl_o.dir_force, w[14]);
		chk("dir input", pad_ctrl_o.dir_input, w[14] & w[15]);
		chk("pull force", pad_ctrl_o.pull_force, w[11]);
		chk("pull value", pad_ctrl_o.pull_value, w[11] ? w[13:12] : 2'h0);
		chk("strength", pad_ctrl_o.strength, w[5:0]);
		chk("fast slew", pad_ctrl_o.fast_slew, {w[4], w[2], w[0]});
	endtask

	task automatic out_sel();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge sys_clk_i);
			indicator_i <= k[1:0];
			interrupt_i <= k[0] ~^ k[1];
			for (int c = 0; c < 8; c++)
			begin
				if (c == 1)
					continue;
				wr(INDICATOR_PIN_OUTPUT_SELECT_ADDR, {5'h0, c[2:0], 5'h0, c[2:0]});
				chk("pin0 select", pin_out_o[0], sel_exp(c, k[0], k[0] ~^ k[1]));
				chk("pin2 select", pin_out_o[1], sel_exp(c, k[1], k[0] ~^ k[1]));
			end
		end
	endtask

	task automatic clk_src();
		logic [7:0] b;
		logic [9:0] one;
		for (int m = 0; m < 2; m++)
		begin
			@(posedge sys_clk_i);
			link_master_i <= m[0];
			for (int c = 0; c < 7; c++)
			for (int i = 0; i < 2; i++)
			begin
				b = {1'b0, c[2:0], i[0], 3'h1};
				one = 10'h001 << src_idx(c, m[0]);
				wr(INDICATOR_PIN_OUTPUT_SELECT_ADDR, {b, b});
				for (int p = 0; p < 2; p++)
				begin
					@(posedge sys_clk_i);
					clk_srcs_i <= clk_srcs_s'(p ? ~one : one);
					@(posedge sys_clk_i);
					#1;
					chk("pin0 clock", pin_out_o[0], (p == 0) ^ i[0]);
					chk("pin2 clock", pin_out_o[1], (p == 0) ^ i[0]);
				end
			end
		end
	endtask

	task automatic clk_div();
		logic [1:0] prev;
		int t0;
		int t1;
		for (int d = 0; d < 2; d++)
		begin
			t0 = 0;
			t1 = 0;
			prev = pin_out_o;
			wr(INDICATOR_PIN_OUTPUT_SELECT_ADDR, d ? 16'h8989 : 16'h0101);
			for (int n = 0; n < 22; n++)
			begin
				@(posedge sys_clk_i);
				clk_srcs_i.crystal_input_clock <= ~clk_srcs_i.crystal_input_clock;
				#1;
				if (n > 5)
				begin
					t0 += int'(pin_out_o[0] != prev[0]);
					t1 += int'(pin_out_o[1] != prev[1]);
				end
				prev = pin_out_o;
			end
			chk("pin0 edges", t0[15:0], d ? 16'h0008 : 16'h0010);
			chk("pin2 edges", t1[15:0], d ? 16'h0008 : 16'h0010);
		end
	endtask

	task automatic mid_reset();
		logic [15:0] v;
		wr(PAD_OVERRIDE_CONFIG_ADDR, 16'h4800);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		chk("pad ctrl in reset", pad_ctrl_o, 16'h0000);
		chk("pins in reset", {14'h0000, pin_out_o}, 16'h0000);
		repeat (5) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(PAD_OVERRIDE_CONFIG_ADDR, v);
		chk("pad after reset", v, 16'h0005);
		rd(INDICATOR_PIN_OUTPUT_SELECT_ADDR, v);
		chk("select after reset", v, 16'h0000);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		reset_values();
		pad_case(16'hffff);
		pad_case(16'h6801);
		pad_case(16'h8014);
		out_sel();
		clk_src();
		clk_div();
		mid_reset();
		test_done();
	end
endmodule
